// ### inc/csr_defs.svh
// offsets, field positions, reset values and counts for the clock select and reset cause block
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH
`define CSR_TRIM_OFF      12'h000
`define CSR_CAUSE_OFF     12'h004
`define CSR_CLKSTAT_OFF   12'h008
`define CSR_VECTOR_OFF    12'h00C
`define CSR_TRIM_RST      4'h0
`define CSR_STARTUP_CNT   11'h400
`define CSR_VEC_RESET     24'h00_0000
`define CSR_VEC_CLKFAIL   24'h00_0004
`define CSR_F_TRAP        0
`define CSR_F_ILLOP       1
`define CSR_F_PIN         2
`define CSR_F_SOFT        3
`define CSR_F_WDOG        4
`define CSR_F_IDLE        5
`define CSR_F_SLEEP       6
`define CSR_F_POWERUP     7
`define CSR_F_BROWNOUT    8
`define CSR_GRP_PLL       3'h7
`define CSR_GRP_PRIMARY   3'h3
`define CSR_GRP_SECONDARY 3'h0
`define CSR_GRP_FAST_RC   3'h1
`define CSR_GRP_SLOW_RC   3'h2
`define CSR_RESP_OKAY     2'h0
`define CSR_RESP_SLVERR   2'h2
`endif

// ### inc/csr_pkg.sv
// types shared by the clock select and reset cause block
package csr_pkg;
    // clock source chosen at power-up
    typedef enum logic [3:0] {
        CSR_SRC_PLL       = 4'b0001,
        CSR_SRC_PRIMARY   = 4'b0010,
        CSR_SRC_SECONDARY = 4'b0100,
        CSR_SRC_INTERNAL  = 4'b1000
    } csr_src_type;
    // role of the oscillator output pin
    typedef enum logic [1:0] {
        CSR_PIN_GPIO  = 2'h0,
        CSR_PIN_DRIVE = 2'h1,
        CSR_PIN_CLOCK_OUT_PIN  = 2'h2
    } csr_pin_type;
    // start-up sequencer states
    typedef enum logic [2:0] {
        CSR_ST_HOLD  = 3'b001,
        CSR_ST_COUNT = 3'b010,
        CSR_ST_RUN   = 3'b100
    } csr_state_type;
endpackage

// ### verilog/csr_startup_counter.sv
// crystal start-up counter: counts oscillator periods before releasing the clock
`timescale 1ns/1ps
`include "csr_defs.svh"
module csr_startup_counter #(
    parameter int WIDTH = 10
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic restart,
    input  wire logic osc_tick,
    output logic      done
);
    logic [WIDTH:0] count;
    wire            at_end = (count == `CSR_STARTUP_CNT);

    // extra top bit marks the full 1024 periods without wrapping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (restart) begin
            count <= '0;
        end else if (osc_tick && !at_end) begin
            count <= count + 1'b1;
        end
    end

    assign done = at_end;
endmodule

// ### verilog/csr_clock_reset.sv
// clock source selection, start-up gating, rc trim and reset cause recording
// Function
// - at power-on or brownout, pick clock source from group and primary fields
// - three-bit group field chooses pll, primary, secondary crystal or internal rc
// - five-bit primary field picks among 13 choices; ignored outside primary groups
// - group 111 pll, 011 primary, 000 secondary, 001 fast rc, 010 slow rc
// - ten-bit counter counts 1024 oscillator periods before releasing the clock
// - start-up count reruns on power-on, brownout and sleep wake-up
// - start-up delay only for primary low-power, standard, low-freq, high-speed crystal (code delays only primary modes 00, 02 and 04)
// - output pin is gpio, crystal drive or clock out per primary mode
// - oscillator input pin is never a general purpose pin
// - four-bit trim field, reset zero, adjusts fast internal rc frequency
// - flags software read/write; hardware touches only named flags per event
// - power-on sets power-up and brownout, clears rest; brownout sets brownout only (code also clears power-up)
// - pin reset running: set pin, clear soft, watchdog, idle, sleep
// - soft reset running: set soft, clear pin, watchdog, idle, sleep
// - pin reset in sleep: set pin and sleep, clear watchdog and idle
// - pin reset in idle: set pin and idle, clear watchdog and sleep
// - interrupt wake from sleep sets sleep flag, resumes at next instruction
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "csr_defs.svh"
module csr_clock_reset (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic [2:0]  OSC_GROUP_SEL,
    input  wire logic [4:0]  PRIMARY_OSC_SEL,
    input  wire logic        OSC_TICK,
    input  wire logic        EV_POWER_ON,
    input  wire logic        EV_BROWNOUT,
    input  wire logic        EV_PIN_RESET,
    input  wire logic        EV_SOFT_RESET,
    input  wire logic        EV_WDOG,
    input  wire logic        EV_INT_WAKE,
    input  wire logic        EV_CLK_FAIL,
    input  wire logic        EV_TRAP_CONFLICT,
    input  wire logic        EV_ILLEGAL_OP,
    input  wire logic        IN_SLEEP,
    input  wire logic        IN_IDLE,
    output logic             CLK_RELEASED,
    output logic [3:0]       CLK_SOURCE,
    output logic [4:0]       PRIMARY_MODE,
    output logic [1:0]       OSC_OUT_ROLE,
    output logic             OSC_IN_GPIO_OK,
    output logic [3:0]       RC_TRIM,
    output logic             VECTOR_LOAD,
    output logic [1:0]       VECTOR_KIND,
    output logic [23:0]      VECTOR_ADDR,
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    // reset release through two flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // configuration latched when leaving power-on or brownout
    logic [2:0] group_sel;
    logic [4:0] prim_sel;
    wire        cfg_load = EV_POWER_ON | EV_BROWNOUT;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            group_sel <= 3'h0;
            prim_sel  <= 5'h00;
        end else if (cfg_load) begin
            group_sel <= OSC_GROUP_SEL;
            prim_sel  <= PRIMARY_OSC_SEL;
        end
    end
    // live straps used until first clocked cycle after release, latched copy after
    logic cfg_seen;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) cfg_seen <= 1'b0;
        else cfg_seen <= 1'b1;
    end
    wire [2:0] grp_now  = cfg_seen ? group_sel : OSC_GROUP_SEL;
    wire [4:0] prim_now = cfg_seen ? prim_sel : PRIMARY_OSC_SEL;

    // group decode; primary field only meaningful in pll and primary groups
    wire grp_pll  = (grp_now == `CSR_GRP_PLL);
    wire grp_prim = (grp_now == `CSR_GRP_PRIMARY);
    wire grp_sec  = (grp_now == `CSR_GRP_SECONDARY);
    wire grp_int  = (grp_now == `CSR_GRP_FAST_RC) | (grp_now == `CSR_GRP_SLOW_RC);
    wire uses_prim = grp_pll | grp_prim;
    wire [4:0] prim_eff = uses_prim ? prim_now : 5'h00;
    csr_pkg::csr_src_type next_src;
    assign next_src = grp_pll  ? csr_pkg::CSR_SRC_PLL :
                      grp_prim ? csr_pkg::CSR_SRC_PRIMARY :
                      grp_sec  ? csr_pkg::CSR_SRC_SECONDARY :
                                 csr_pkg::CSR_SRC_INTERNAL;

    // crystal modes needing the start-up delay (primary group only)
    wire xtal_mode = grp_prim & ((prim_now == 5'h04) | (prim_now == 5'h02) |
                                 (prim_now == 5'h00));
    // pin role per primary mode, including pll variants
    wire pin_gpio = ~uses_prim | (prim_now == 5'h0D) | (prim_now == 5'h0E) |
                    (prim_now == 5'h0F) | (prim_now == 5'h01) | (prim_now == 5'h0A) |
                    (prim_now == 5'h03) | (grp_prim & (prim_now == 5'h0C)) |
                    (grp_prim & (prim_now == 5'h08));
    wire pin_clock_out_pin = grp_prim & ((prim_now == 5'h0B) | (prim_now == 5'h09));
    csr_pkg::csr_pin_type next_role;
    assign next_role = pin_clock_out_pin ? csr_pkg::CSR_PIN_CLOCK_OUT_PIN :
                       pin_gpio ? csr_pkg::CSR_PIN_GPIO : csr_pkg::CSR_PIN_DRIVE;

    // start-up sequencing
    csr_pkg::csr_state_type state;
    csr_pkg::csr_state_type next_state;
    wire restart = cfg_load | (EV_INT_WAKE & IN_SLEEP) | (EV_WDOG & IN_SLEEP) |
                   (EV_PIN_RESET & IN_SLEEP);
    wire cnt_done;
    csr_startup_counter #(.WIDTH(10)) u_count (
        .clk      (CLK),
        .rst_n    (rst_n),
        .restart  (restart | (state == csr_pkg::CSR_ST_HOLD)),
        .osc_tick (OSC_TICK),
        .done     (cnt_done)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            csr_pkg::CSR_ST_HOLD:  next_state = xtal_mode ? csr_pkg::CSR_ST_COUNT
                                                          : csr_pkg::CSR_ST_RUN;
            csr_pkg::CSR_ST_COUNT: if (cnt_done) next_state = csr_pkg::CSR_ST_RUN;
            csr_pkg::CSR_ST_RUN:   if (restart) next_state = csr_pkg::CSR_ST_HOLD;
            default:               next_state = csr_pkg::CSR_ST_HOLD;
        endcase
    end
    // restart out of count also goes back to hold
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) state <= csr_pkg::CSR_ST_HOLD;
        else if (restart && state == csr_pkg::CSR_ST_COUNT) state <= csr_pkg::CSR_ST_HOLD;
        else state <= next_state;
    end

    // registered clock status outputs
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            CLK_RELEASED   <= 1'b0;
            CLK_SOURCE     <= 4'h0;
            PRIMARY_MODE   <= 5'h00;
            OSC_OUT_ROLE   <= 2'h0;
            OSC_IN_GPIO_OK <= 1'b0;
        end else begin
            CLK_RELEASED   <= (next_state == csr_pkg::CSR_ST_RUN) && !restart;
            CLK_SOURCE     <= next_src;
            PRIMARY_MODE   <= prim_eff;
            OSC_OUT_ROLE   <= next_role;
            OSC_IN_GPIO_OK <= 1'b0;
        end
    end

    // bus write path: take address and data in either order
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wire         aw_fire  = S_AXI_AWVALID & S_AXI_AWREADY;
    wire         w_fire   = S_AXI_WVALID & S_AXI_WREADY;
    wire         wr_go    = aw_held & w_held & ~S_AXI_BVALID;
    wire         wr_trim  = wr_go & (aw_addr == `CSR_TRIM_OFF);
    wire         wr_cause = wr_go & (aw_addr == `CSR_CAUSE_OFF);
    wire         wr_known = wr_trim | wr_cause;
    wire         next_aw_held = wr_go ? 1'b0 : (aw_held | aw_fire);
    wire         next_w_held  = wr_go ? 1'b0 : (w_held | w_fire);
    // readies are flops that mirror the next held state, so no output is combinational
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end else begin
            if (aw_fire) aw_addr <= S_AXI_AWADDR;
            if (w_fire) w_data <= S_AXI_WDATA;
            if (w_fire) w_strb <= S_AXI_WSTRB;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            S_AXI_AWREADY <= ~next_aw_held;
            S_AXI_WREADY  <= ~next_w_held;
        end
    end
    // write response
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `CSR_RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_known ? `CSR_RESP_OKAY : `CSR_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // trim register, low byte lane only
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) RC_TRIM <= `CSR_TRIM_RST;
        else if (wr_trim && w_strb[0]) RC_TRIM <= w_data[3:0];
    end

    // reset cause flags: each event sets/clears only its named flags
    logic [8:0] cause;
    logic [8:0] set_m;
    logic [8:0] clr_m;
    wire pin_run  = EV_PIN_RESET & ~IN_SLEEP & ~IN_IDLE;
    wire pin_slp  = EV_PIN_RESET & IN_SLEEP;
    wire pin_idl  = EV_PIN_RESET & IN_IDLE & ~IN_SLEEP;
    wire wd_run   = EV_WDOG & ~IN_SLEEP;
    wire wd_wake  = EV_WDOG & IN_SLEEP;
    wire int_wake = EV_INT_WAKE & IN_SLEEP;
    always_comb begin
        set_m = 9'h000;
        clr_m = 9'h000;
        if (EV_POWER_ON) begin
            clr_m = 9'h07F;
            set_m = 9'h180;
        end else if (EV_BROWNOUT) begin
            set_m[`CSR_F_BROWNOUT] = 1'b1;
            clr_m[`CSR_F_POWERUP]  = 1'b1;
        end else begin
            if (pin_run) begin
                set_m[`CSR_F_PIN] = 1'b1;
                clr_m = clr_m | 9'h078;
            end
            if (EV_SOFT_RESET) begin
                set_m[`CSR_F_SOFT] = 1'b1;
                clr_m = clr_m | 9'h074;
            end
            if (pin_slp) begin
                set_m = set_m | 9'h044;
                clr_m = clr_m | 9'h030;
            end
            if (pin_idl) begin
                set_m = set_m | 9'h024;
                clr_m = clr_m | 9'h050;
            end
            if (wd_run) begin
                set_m[`CSR_F_WDOG] = 1'b1;
                clr_m = clr_m | 9'h06C;
            end
            if (wd_wake) set_m = set_m | 9'h050;
            if (int_wake) set_m[`CSR_F_SLEEP] = 1'b1;
            if (EV_TRAP_CONFLICT) set_m[`CSR_F_TRAP] = 1'b1;
            if (EV_ILLEGAL_OP) set_m[`CSR_F_ILLOP] = 1'b1;
        end
    end
    // software write first, then hardware clear, then hardware set wins
    wire [8:0] sw_val = (wr_cause && w_strb[0]) ? {cause[8], w_data[7:0]} : cause;
    wire [8:0] sw_all = (wr_cause && w_strb[1]) ? {w_data[8], sw_val[7:0]} : sw_val;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) cause <= 9'h180;
        else cause <= (sw_all & ~clr_m) | set_m;
    end

    // restart address: clock failure trap leaves flags alone
    wire restart_zero = EV_POWER_ON | EV_BROWNOUT | pin_run | pin_slp | pin_idl |
                        EV_SOFT_RESET | wd_run | EV_TRAP_CONFLICT | EV_ILLEGAL_OP;
    wire resume_next  = wd_wake | int_wake;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            VECTOR_LOAD <= 1'b0;
            VECTOR_KIND <= 2'h0;
            VECTOR_ADDR <= `CSR_VEC_RESET;
        end else begin
            VECTOR_LOAD <= restart_zero | resume_next | EV_CLK_FAIL;
            VECTOR_KIND <= restart_zero ? 2'h0 : resume_next ? 2'h1 : 2'h2;
            VECTOR_ADDR <= (EV_CLK_FAIL && !restart_zero && !resume_next) ?
                           `CSR_VEC_CLKFAIL : `CSR_VEC_RESET;
        end
    end

    // read path, one cycle
    wire [31:0] rd_mux = (S_AXI_ARADDR == `CSR_TRIM_OFF)    ? {28'h000_0000, RC_TRIM} :
                         (S_AXI_ARADDR == `CSR_CAUSE_OFF)   ? {23'h00_0000, cause} :
                         (S_AXI_ARADDR == `CSR_CLKSTAT_OFF) ?
                             {19'h0_0000, CLK_RELEASED, CLK_SOURCE, prim_sel, group_sel} :
                         (S_AXI_ARADDR == `CSR_VECTOR_OFF)  ? {8'h00, VECTOR_ADDR} :
                                                              32'h0000_0000;
    wire rd_known = (S_AXI_ARADDR == `CSR_TRIM_OFF) | (S_AXI_ARADDR == `CSR_CAUSE_OFF) |
                    (S_AXI_ARADDR == `CSR_CLKSTAT_OFF) | (S_AXI_ARADDR == `CSR_VECTOR_OFF);
    // ready registered from the next rvalid; low while an answer stands
    wire next_rvalid = (S_AXI_ARVALID & S_AXI_ARREADY) | (S_AXI_RVALID & ~S_AXI_RREADY);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) S_AXI_ARREADY <= 1'b0;
        else S_AXI_ARREADY <= ~next_rvalid;
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= `CSR_RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_mux;
            S_AXI_RRESP  <= rd_known ? `CSR_RESP_OKAY : `CSR_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // checks
    a_pin_never_gpio: assert property (@(posedge CLK) disable iff (!rst_n)
        !OSC_IN_GPIO_OK) else $error("input pin offered as gpio");
    a_por_flags: assert property (@(posedge CLK) disable iff (!rst_n)
        EV_POWER_ON |=> cause == 9'h180) else $error("power-on flags wrong");
    a_brown_flags: assert property (@(posedge CLK) disable iff (!rst_n)
        (EV_BROWNOUT && !EV_POWER_ON) |=> cause[8] && !cause[7])
        else $error("brownout flags wrong");
    a_soft_flags: assert property (@(posedge CLK) disable iff (!rst_n)
        (EV_SOFT_RESET && !cfg_load) |=> cause[3] && (cause[6:4] == 3'h0) && !cause[2])
        else $error("soft reset flags wrong");
    a_int_wake: assert property (@(posedge CLK) disable iff (!rst_n)
        (int_wake && !cfg_load) |=> cause[6]) else $error("sleep flag not set");
    a_clkfail_vec: assert property (@(posedge CLK) disable iff (!rst_n)
        (EV_CLK_FAIL && !restart_zero && !resume_next) |=> VECTOR_ADDR == 24'h00_0004)
        else $error("clock fail vector wrong");
    a_xtal_wait: assert property (@(posedge CLK) disable iff (!rst_n)
        (state == csr_pkg::CSR_ST_COUNT && !cnt_done) |=> !CLK_RELEASED)
        else $error("clock released early");
    a_trim_hold: assert property (@(posedge CLK) disable iff (!rst_n)
        !wr_trim |=> RC_TRIM == $past(RC_TRIM)) else $error("trim changed");
    c_xtal_start: cover property (@(posedge CLK) disable iff (!rst_n)
        state == csr_pkg::CSR_ST_COUNT ##1 state == csr_pkg::CSR_ST_RUN);
    c_pin_sleep: cover property (@(posedge CLK) disable iff (!rst_n) pin_slp);
    c_trim_write: cover property (@(posedge CLK) disable iff (!rst_n) wr_trim);
endmodule

// ### dv/csr_osc_model.sv
// oscillator stand-in that gives one tick every period clocks while running
`timescale 1ns/1ps
module csr_osc_model (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [3:0] period,
    output logic            tick
);
    logic [3:0] phase;

    // a stopped crystal gives no edges at all; period picks a fast or a slow part
    always_ff @(posedge clk) begin
        if (!run) begin
            phase <= 4'h0;
            tick  <= 1'b0;
        end else begin
            tick  <= (phase == period - 4'h1);
            phase <= (phase == period - 4'h1) ? 4'h0 : phase + 4'h1;
        end
    end
endmodule

// ### dv/tb.sv
// self-checking bench: clock selection, start-up count, rc trim and reset cause
`timescale 1ns/1ps
`include "csr_defs.svh"
module tb;
    logic        clk = 1'b0;
    logic        rst_n;
    logic [2:0]  grp;
    logic [4:0]  prim, pmode;
    logic [8:0]  ev;
    logic        slp, idl, osc_run, osc_tick, rel, gpio_ok, vld;
    logic [3:0]  osc_per, src, trim, wstrb;
    logic [1:0]  role, vkind, bresp, rresp;
    logic [23:0] vaddr;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [8:0]  pat;
    int          ticks = 0;
    int          mismatches = 0;
    int          num_checks = 0;
    // clock cases: straps, source, pin role (3 = unchecked), mode, crystal, restart event
    logic [2:0]  c_grp [12] = '{3'h7, 3'h7, 3'h7, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h0,
                               3'h1, 3'h2};
    logic [4:0]  c_prim [12] = '{5'h0D, 5'h01, 5'h05, 5'h0B, 5'h08, 5'h09, 5'h04, 5'h02, 5'h00,
                                5'h1F, 5'h1F, 5'h1F};
    logic [3:0]  c_src [12] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h4,
                               4'h8, 4'h8};
    logic [1:0]  c_role [12] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h1, 2'h1, 2'h3,
                                2'h3, 2'h3};
    logic [11:0] c_xt = 12'h1C0;
    logic [8:0]  c_rr [12] = '{9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h020, 9'h002, 9'h010,
                              9'h0, 9'h0, 9'h0};
    // cause cases: event, sleep, idle, vector kind, flags set, flags cleared
    logic [8:0]  e_ev [12] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h004, 9'h004, 9'h010, 9'h010,
                              9'h020, 9'h040, 9'h080, 9'h100};
    logic [11:0] e_sl = 12'h190;
    logic [11:0] e_id = 12'h020;
    logic [1:0]  e_vk [12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2,
                              2'h0, 2'h0};
    logic [8:0]  e_st [12] = '{9'h180, 9'h100, 9'h004, 9'h008, 9'h044, 9'h024, 9'h010, 9'h050,
                              9'h040, 9'h000, 9'h001, 9'h002};
    logic [8:0]  e_cl [12] = '{9'h07F, 9'h080, 9'h078, 9'h074, 9'h030, 9'h050, 9'h06C, 9'h000,
                              9'h000, 9'h000, 9'h000, 9'h000};

    // system clock and the oscillator ticks seen by the bench
    always #5 clk = ~clk;
    always @(posedge clk) if (osc_tick === 1'b1) ticks <= ticks + 1;

    csr_osc_model i_osc (.clk(clk), .run(osc_run), .period(osc_per), .tick(osc_tick));

    csr_clock_reset i_dut (
        .CLK(clk), .RESET_N(rst_n), .OSC_GROUP_SEL(grp), .PRIMARY_OSC_SEL(prim),
        .OSC_TICK(osc_tick), .EV_POWER_ON(ev[0]), .EV_BROWNOUT(ev[1]), .EV_PIN_RESET(ev[2]),
        .EV_SOFT_RESET(ev[3]), .EV_WDOG(ev[4]), .EV_INT_WAKE(ev[5]), .EV_CLK_FAIL(ev[6]),
        .EV_TRAP_CONFLICT(ev[7]), .EV_ILLEGAL_OP(ev[8]), .IN_SLEEP(slp), .IN_IDLE(idl),
        .CLK_RELEASED(rel), .CLK_SOURCE(src), .PRIMARY_MODE(pmode), .OSC_OUT_ROLE(role),
        .OSC_IN_GPIO_OK(gpio_ok), .RC_TRIM(trim), .VECTOR_LOAD(vld), .VECTOR_KIND(vkind),
        .VECTOR_ADDR(vaddr), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );

    task automatic print_verdict();
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [34:0] seen, input logic [34:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // reset held five cycles, then room for the two-flop release
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // one write: address and data offered together, each dropped once taken
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'h3, 3'b111};
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        chk("write resp", 35'({bvalid, bresp}), 35'({1'b1, er}));
    endtask

    // one read, data taken at the edge where rvalid is seen
    task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        chk("read", 35'({rvalid, rresp, rdata}), 35'({1'b1, er, ed}));
    endtask

    // one-cycle event; sleep and idle levels hold across it; waits for the vector load
    task automatic pulse(input logic [8:0] m, input logic s, input logic i);
        int n;
        @(posedge clk);
        {ev, slp, idl} <= {m, s, i};
        @(posedge clk);
        {ev, slp, idl} <= '0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (vld !== 1'b1 && n < 4);
    endtask

    // start the oscillator and count its ticks until the clock is handed on
    task automatic release_wait(input logic xt, input logic [3:0] per);
        int n;
        int t0;
        {osc_per, osc_run} <= {per, 1'b1};
        t0 = ticks;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rel !== 1'b1 && n < 7000);
        if (xt) chk("start ticks", 35'(ticks - t0), 35'h0_0000_0400);
        else chk("quick release", 35'(n < 10), 35'(1'b1));
    endtask

    // hang guard, far beyond the expected run of some 31k cycles
    initial begin
        #800_000;
        mismatches++;
        print_verdict();
    end

    initial begin
        {rst_n, ev, slp, idl, osc_run, osc_per, grp, prim} = '0;
        {awaddr, wdata, wstrb, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
        do_reset();
        chk("trim pin", 35'(trim), 35'(4'h0));
        axr(`CSR_CAUSE_OFF, 32'h0000_0180, `CSR_RESP_OKAY);
        axr(`CSR_TRIM_OFF, 32'h0000_0000, `CSR_RESP_OKAY);
        axw(`CSR_TRIM_OFF, 32'hFFFF_FFFF, `CSR_RESP_OKAY);
        chk("trim pin", 35'(trim), 35'(4'hF));
        axr(`CSR_TRIM_OFF, 32'h0000_000F, `CSR_RESP_OKAY);
        axw(`CSR_TRIM_OFF, 32'h0000_0008, `CSR_RESP_OKAY);
        axr(`CSR_TRIM_OFF, 32'h0000_0008, `CSR_RESP_OKAY);
        axw(12'h010, 32'h0000_0001, `CSR_RESP_SLVERR);
        axr(12'h010, 32'h0000_0000, `CSR_RESP_SLVERR);
        // every strap case from a clean power-on; crystals restart after a wake or brownout
        for (int k = 0; k < 12; k++) begin
            do_reset();
            {grp, prim, osc_run} <= {c_grp[k], c_prim[k], 1'b0};
            pulse(9'h001, 1'b0, 1'b0);
            release_wait(c_xt[k], 4'h4);
            chk("source", 35'(src), 35'(c_src[k]));
            if (c_role[k] != 2'h3) chk("out role", 35'(role), 35'(c_role[k]));
            chk("in gpio", 35'(gpio_ok), 35'(1'b0));
            chk("mode", 35'(pmode), 35'(c_grp[k][1:0] == 2'h3 ? c_prim[k] : 5'h00));
            axr(`CSR_CLKSTAT_OFF, {19'h0, 1'b1, c_src[k], c_prim[k], c_grp[k]},
                `CSR_RESP_OKAY);
            if (c_rr[k] != 9'h0) begin
                osc_run <= 1'b0;
                pulse(c_rr[k], 1'b1, 1'b0);
                release_wait(1'b1, 4'h6);
            end
        end
        // every cause event over an all-clear and an all-set starting pattern
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 12; k++) begin
                pat = p ? 9'h1FF : 9'h000;
                axw(`CSR_CAUSE_OFF, {23'h0, pat}, `CSR_RESP_OKAY);
                pulse(e_ev[k], e_sl[k], e_id[k]);
                chk("vector", 35'({vld, vkind}), 35'({1'b1, e_vk[k]}));
                if (e_vk[k] == 2'h0) chk("vec addr", 35'(vaddr), 35'(`CSR_VEC_RESET));
                if (e_vk[k] == 2'h2) chk("vec addr", 35'(vaddr), 35'(`CSR_VEC_CLKFAIL));
                axr(`CSR_CAUSE_OFF, {23'h0, (pat & ~e_cl[k]) | e_st[k]},
                    `CSR_RESP_OKAY);
            end
        end
        print_verdict();
    end
endmodule
